/* core/pfl_pkg.sv */
// register numbers, field layouts and reset values of the processor fault log bank
// assumes a 32-bit classic wishbone slave, byte address = 4 * register number
package pfl_pkg;
  // ********************************************************
  // register numbers (word index)
  // ********************************************************
  localparam logic [7:0] IDX_MCHK_STATUS = 8'h26;
  localparam logic [7:0] IDX_INT_ENABLE  = 8'h80;
  localparam logic [7:0] IDX_INT_OTHER   = 8'h81;
  localparam logic [7:0] IDX_FAULT_SUM   = 8'h82;
  localparam logic [7:0] IDX_SILO        = 8'h83;
  localparam logic [7:0] IDX_TMO_ADDR    = 8'h84;
  localparam logic [7:0] IDX_CACHE_CTRL  = 8'h85;
  localparam logic [7:0] IDX_REV_FIRST   = 8'h86;
  localparam logic [7:0] IDX_REV_SECOND  = 8'h87;
  localparam logic [7:0] IDX_CLR_TMO     = 8'h88;
  localparam logic [7:0] IDX_WBUF_DRAIN  = 8'h89;
  // ********************************************************
  // field positions and sizes
  // ********************************************************
  localparam int          FSR_FAULT_BIT  = 0;
  localparam int          FSR_TMO_BIT    = 1;
  localparam int          FSR_LOCK_BIT   = 2;
  localparam int          FSR_CNT_LSB    = 8;
  localparam int          CACHE_EN_BIT   = 0;
  localparam int          SILO_DEPTH     = 256;
  localparam int          SILO_AW        = 8;
  localparam logic [8:0]  SILO_FULL      = 9'h100;
  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [31:0] RST_INT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_CACHE_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_TMO_ADDR   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
endpackage

/* core/pfl_regs.sv */
// processor fault log register bank: interrupt enables, interconnect fault summary,
// 256-entry transaction silo, timeout address, cache enable, revision and trigger registers.
// assumes the interconnect monitor and wishbone master run on clk_i.
//
// Function
// - registers decoded by number: 26 and 80 through 89.
// - interrupt, clear-timeout and drain registers discard written data.
// - read-as-zero bit positions always return zero.
// - software-zero bits are stored as written and read back unchanged.
// - don't-care write bits have no effect.
// - interrupt enable register is write-only and selects taken interrupt classes.
// - fault summary accumulates every interconnect fault and timeout.
// - read-only silo records interconnect transactions, at most 256 entries.
// - silo locks, freezing its contents, when a fault is seen.
// - each read of a locked silo returns and removes one entry.
// - timed-out transaction address captured in the timeout address register.
// - cache control is read/write and governs cache use.
// - revision registers are read-only; writes leave them unchanged.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pfl_regs
  import pfl_pkg::*;
#(
  parameter logic [31:0] REV_FIRST_VAL  = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] REV_SECOND_VAL = 32'h0000_0002  // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:2]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // interconnect monitor
  input  wire logic        mon_valid_i,
  input  wire logic [31:0] mon_data_i,
  input  wire logic        mon_fault_i,
  input  wire logic        mon_timeout_i,
  input  wire logic [31:0] mon_addr_i,
  input  wire logic [31:0] mchk_status_i,
  // processor controls
  output logic      [31:0] int_enable_o,
  output logic             int_other_cpu_o,
  output logic             cache_en_o,
  output logic             wbuf_drain_o
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [31:0] ien;
    logic [31:0] cache;
    logic        fault;
    logic        tmo;
    logic        lock;
    logic [31:0] eaddr;
    logic [7:0]  wp;
    logic [8:0]  cnt;
    logic        ipi;
    logic        drain;
  } pfl_state_s;

  pfl_state_s s_q;
  pfl_state_s s_d;

  logic [31:0] silo_mem [SILO_DEPTH];

  // byte-lane merge for stored registers
  function automatic logic [31:0] pfl_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic        req;
  logic        wr;
  logic        rd;
  logic        rec;
  logic [7:0]  oldest;

  assign req    = cyc_i & stb_i & ~s_q.ack;
  assign wr     = req & we_i;
  assign rd     = req & ~we_i;
  // the silo keeps recording until locked; a full silo overwrites its oldest entry
  assign rec    = mon_valid_i & ~s_q.lock;
  assign oldest = s_q.wp - s_q.cnt[7:0];

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    s_d       = s_q;
    s_d.ack   = req;
    s_d.ipi   = 1'b0;
    s_d.drain = 1'b0;
    if (wr && adr_i == IDX_FAULT_SUM && sel_i[0] && dat_i[FSR_FAULT_BIT]) begin
      s_d.fault = 1'b0;
      s_d.lock  = 1'b0;
    end
    if (wr && adr_i == IDX_CLR_TMO) begin
      s_d.tmo = 1'b0;
    end
    if (mon_fault_i) begin
      s_d.fault = 1'b1;
      s_d.lock  = 1'b1;
    end
    if (mon_timeout_i) begin
      s_d.tmo = 1'b1;
      if (!s_q.tmo) begin
        s_d.eaddr = mon_addr_i; // first timeout is kept until cleared
      end
    end
    if (rec) begin
      s_d.wp = s_q.wp + 8'h01;
      if (s_q.cnt != SILO_FULL) begin
        s_d.cnt = s_q.cnt + 9'h001;
      end
    end
    // writes
    if (wr) begin
      case (adr_i)
        IDX_INT_ENABLE: s_d.ien   = pfl_merge(s_q.ien, dat_i, sel_i);
        IDX_CACHE_CTRL: s_d.cache = pfl_merge(s_q.cache, dat_i, sel_i);
        IDX_INT_OTHER:  s_d.ipi   = 1'b1;
        IDX_WBUF_DRAIN: s_d.drain = 1'b1;
        default:        s_d.ien   = s_d.ien; // read-only or unmapped
      endcase
    end
    // reads
    s_d.dat = ZERO_WORD;
    if (rd) begin
      case (adr_i)
        IDX_MCHK_STATUS: s_d.dat = mchk_status_i;
        IDX_FAULT_SUM: begin
          s_d.dat[FSR_FAULT_BIT]             = s_q.fault;
          s_d.dat[FSR_TMO_BIT]               = s_q.tmo;
          s_d.dat[FSR_LOCK_BIT]              = s_q.lock;
          s_d.dat[FSR_CNT_LSB +: 9]          = s_q.cnt; // others zero
        end
        IDX_SILO: begin
          if (s_q.cnt != 9'h000) begin
            s_d.dat = s_q.lock ? silo_mem[oldest] : silo_mem[s_q.wp - 8'h01];
          end
          if (s_q.lock && s_q.cnt != 9'h000) begin
            s_d.cnt = s_q.cnt - 9'h001;
          end
        end
        IDX_TMO_ADDR:    s_d.dat = s_q.eaddr;
        IDX_CACHE_CTRL:  s_d.dat = s_q.cache;
        IDX_REV_FIRST:   s_d.dat = REV_FIRST_VAL;
        IDX_REV_SECOND:  s_d.dat = REV_SECOND_VAL;
        default:         s_d.dat = ZERO_WORD;   // write-only and unmapped
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.ien   <= RST_INT_ENABLE;
      s_q.cache <= RST_CACHE_CTRL;
      s_q.eaddr <= RST_TMO_ADDR;
      s_q.lock  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // silo storage has no reset; the count guards stale words
  always_ff @(posedge clk_i) begin
    if (!rst_i && rec) begin
      silo_mem[s_q.wp] <= mon_data_i;
    end
  end

  assign ack_o           = s_q.ack;
  assign dat_o           = s_q.dat;
  assign int_enable_o    = s_q.ien;
  assign cache_en_o      = s_q.cache[CACHE_EN_BIT];
  assign int_other_cpu_o = s_q.ipi;
  assign wbuf_drain_o    = s_q.drain;

  // ********************************************************
  // checks
  // ********************************************************
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");

  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o) else $error("request not answered");

  wo_read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_INT_ENABLE) |=> (ack_o && dat_o == ZERO_WORD))
    else $error("write-only register read nonzero");

  fault_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_fault_i |=> (s_q.lock && s_q.fault)) else $error("fault did not lock silo");

  lock_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.lock && !wr) |=> $stable(s_q.wp)) else $error("locked silo still recording");

  silo_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_SILO && s_q.lock && s_q.cnt != 9'h000)
    |=> s_q.cnt == $past(s_q.cnt) - 9'h001) else $error("locked silo read did not pop");

  silo_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.cnt <= SILO_FULL) else $error("silo count beyond depth");

  tmo_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mon_timeout_i && !s_q.tmo) |=> (s_q.tmo && s_q.eaddr == $past(mon_addr_i)))
    else $error("timeout address not captured");

  clr_tmo_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_CLR_TMO && !mon_timeout_i) |=> !s_q.tmo)
    else $error("timeout flag not cleared");

  drain_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_WBUF_DRAIN) |=> wbuf_drain_o ##1 !wbuf_drain_o)
    else $error("drain pulse wrong");

  cache_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_CACHE_CTRL && sel_i[0]) |=> cache_en_o == $past(dat_i[0]))
    else $error("cache enable not updated");

  // ********************************************************
  // bus checks
  // ********************************************************
  // read data is forced to zero outside the ack cycle, so a master that
  // samples one cycle late sees zero rather than a stale word
  ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");

  dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == ZERO_WORD) else $error("read data outside ack");

  mchk_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_MCHK_STATUS) |=> dat_o == $past(mchk_status_i))
    else $error("machine check status read wrong");

  rev_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_REV_FIRST) |=> dat_o == REV_FIRST_VAL)
    else $error("first revision read wrong");

  rev_second_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_REV_SECOND) |=> dat_o == REV_SECOND_VAL)
    else $error("second revision read wrong");

  trig_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && (adr_i == IDX_INT_OTHER || adr_i == IDX_CLR_TMO || adr_i == IDX_WBUF_DRAIN))
    |=> dat_o == ZERO_WORD) else $error("trigger register read nonzero");

  // ********************************************************
  // fault summary checks
  // ********************************************************
  // flags are sticky: only an explicit software write may drop them,
  // otherwise a fault between two polls would be lost
  fsr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_FAULT_SUM) |=> (dat_o[31:17] == 15'h0000 && dat_o[7:3] == 5'h00))
    else $error("summary reserved bits nonzero");

  fsr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_FAULT_SUM)
    |=> (dat_o[FSR_FAULT_BIT] == $past(s_q.fault) && dat_o[FSR_TMO_BIT] == $past(s_q.tmo)))
    else $error("summary flags read wrong");

  fault_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.fault && !(wr && adr_i == IDX_FAULT_SUM)) |=> s_q.fault)
    else $error("fault flag dropped");

  tmo_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.tmo && !(wr && adr_i == IDX_CLR_TMO)) |=> s_q.tmo)
    else $error("timeout flag dropped");

  tmo_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mon_timeout_i |=> s_q.tmo) else $error("timeout not recorded");

  eaddr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.tmo |=> $stable(s_q.eaddr)) else $error("timeout address overwritten");

  tmo_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_TMO_ADDR) |=> dat_o == $past(s_q.eaddr))
    else $error("timeout address read wrong");

  unlock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_FAULT_SUM && sel_i[0] && dat_i[FSR_FAULT_BIT] && !mon_fault_i)
    |=> !s_q.lock) else $error("silo not unlocked");

  // ********************************************************
  // silo checks
  // ********************************************************
  // the count saturates at the depth; the write pointer keeps wrapping,
  // so a full unlocked silo silently loses its oldest record
  silo_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rec && s_q.cnt != SILO_FULL) |=> s_q.cnt == $past(s_q.cnt) + 9'h001)
    else $error("silo record not counted");

  silo_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rec && s_q.cnt == SILO_FULL) |=> s_q.cnt == SILO_FULL)
    else $error("full silo count moved");

  silo_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_SILO && s_q.cnt == 9'h000) |=> dat_o == ZERO_WORD)
    else $error("empty silo read nonzero");

  silo_peek_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && adr_i == IDX_SILO && !s_q.lock && !mon_valid_i) |=> $stable(s_q.cnt))
    else $error("unlocked silo read popped");

  // ********************************************************
  // control register checks
  // ********************************************************
  // trigger outputs are one-cycle pulses; a held level would repeat
  // the action on every clock
  ipi_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_INT_OTHER) |=> int_other_cpu_o ##1 !int_other_cpu_o)
    else $error("other cpu pulse wrong");

  ien_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == IDX_INT_ENABLE && sel_i == 4'hF) |=> int_enable_o == $past(dat_i))
    else $error("interrupt enable not written");

  ien_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && adr_i == IDX_INT_ENABLE) |=> $stable(int_enable_o))
    else $error("interrupt enable changed");

  cache_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && adr_i == IDX_CACHE_CTRL) |=> $stable(s_q.cache))
    else $error("cache control changed");

endmodule
`default_nettype wire

/* sim/pfl_mon_model.sv */
// interconnect monitor model: records, faults and timeouts on the clk_i domain
// assumes the bench calls its tasks and that no two tasks run at once
`timescale 1ns/10ps
`default_nettype none
module pfl_mon_model #(
  parameter logic [31:0] MCHK = 32'h0000_0C3A
) (
  // clock
  input  wire logic        clk_i,
  // monitor lines
  output var  logic        mon_valid_o,
  output var  logic [31:0] mon_data_o,
  output var  logic        mon_fault_o,
  output var  logic        mon_timeout_o,
  output var  logic [31:0] mon_addr_o,
  output      logic [31:0] mchk_status_o
);
  assign mchk_status_o = MCHK;
  initial begin
    mon_valid_o   = 1'b0;
    mon_data_o    = 32'h0000_0000;
    mon_fault_o   = 1'b0;
    mon_timeout_o = 1'b0;
    mon_addr_o    = 32'h0000_0000;
  end
  // idle data lines show the inverse so a stale value never matches
  task automatic rec(input logic [31:0] d);
    @(posedge clk_i);
    mon_valid_o <= 1'b1;
    mon_data_o  <= d;
    @(posedge clk_i);
    mon_valid_o <= 1'b0;
    mon_data_o  <= ~d;
  endtask
  task automatic flt();
    @(posedge clk_i);
    mon_fault_o <= 1'b1;
    @(posedge clk_i);
    mon_fault_o <= 1'b0;
  endtask
  task automatic tmo(input logic [31:0] a);
    @(posedge clk_i);
    mon_timeout_o <= 1'b1;
    mon_addr_o    <= a;
    @(posedge clk_i);
    mon_timeout_o <= 1'b0;
    mon_addr_o    <= ~a;
  endtask
endmodule
`default_nettype wire

/* sim/pfl_regs_tb_top.sv */
// self-checking bench for the processor fault log register bank
// assumes one 250 MHz clock and a wishbone slave acking one cycle after a request
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, v) begin samples_checked++; if ((v) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, v); end end
module pfl_regs_tb_top;
  import pfl_pkg::*;
  localparam logic [31:0] MCHK = 32'h0000_0C3A;
  localparam logic [31:0] REV1 = 32'h0000_0011; // arbitrary value
  localparam logic [31:0] REV2 = 32'h0000_0022; // arbitrary value
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_o, ioc, cen, wbd, mv, mf, mt;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, q, ien, md, ma, ms;
  logic [1:0]  pls;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  always #2 clk_i = ~clk_i;
  pfl_regs #(.REV_FIRST_VAL(REV1), .REV_SECOND_VAL(REV2)) DUT (.clk_i, .rst_i, .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o, .ack_o,
    .mon_valid_i(mv), .mon_data_i(md), .mon_fault_i(mf), .mon_timeout_i(mt),
    .mon_addr_i(ma), .mchk_status_i(ms), .int_enable_o(ien), .int_other_cpu_o(ioc),
    .cache_en_o(cen), .wbuf_drain_o(wbd));
  pfl_mon_model #(.MCHK(MCHK)) MON (.clk_i, .mon_valid_o(mv), .mon_data_o(md),
    .mon_fault_o(mf), .mon_timeout_o(mt), .mon_addr_o(ma), .mchk_status_o(ms));
  // ********************************************************
  // bus access
  // ********************************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = dat_o;
    pls = {ioc, wbd};
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, q)
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // stops a run that never reaches test_done; a hung handshake already gives up after 20 cycles in wb
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(IDX_INT_ENABLE, ZERO_WORD, "int enable");
    rd(IDX_CACHE_CTRL, RST_CACHE_CTRL, "cache");
    rd(IDX_FAULT_SUM, ZERO_WORD, "summary");
    rd(IDX_MCHK_STATUS, MCHK, "mchk");
    $display("test reset done");
    wb(1'b1, IDX_INT_ENABLE, 32'hA5A5_5A5A);
    `CHK("int out", 32'hA5A5_5A5A, ien)
    rd(IDX_INT_ENABLE, ZERO_WORD, "int wo");
    wb(1'b1, IDX_CACHE_CTRL, 32'hF0F0_0001);
    rd(IDX_CACHE_CTRL, 32'hF0F0_0001, "cache rw");
    `CHK("cache en", 1'b1, cen)
    wb(1'b1, IDX_REV_FIRST, 32'hFFFF_FFFF);
    wb(1'b1, IDX_REV_SECOND, 32'hFFFF_FFFF);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(IDX_REV_FIRST, REV1, "rev1");
    rd(IDX_REV_SECOND, REV2, "rev2");
    rd(8'h40, ZERO_WORD, "unmapped");
    $display("test store done");
    for (int i = 1; i <= 3; i++) MON.rec(32'h1111_0000 | 32'(i));
    rd(IDX_FAULT_SUM, 32'h0000_0300, "count");
    rd(IDX_SILO, 32'h1111_0003, "newest");
    MON.flt();
    MON.rec(32'hDEAD_0000);
    rd(IDX_FAULT_SUM, 32'h0000_0305, "locked");
    for (int i = 1; i <= 3; i++) rd(IDX_SILO, 32'h1111_0000 | 32'(i), "pop");
    rd(IDX_SILO, ZERO_WORD, "empty");
    wb(1'b1, IDX_FAULT_SUM, 32'hFFFF_FFFE);
    rd(IDX_FAULT_SUM, 32'h0000_0005, "dont care");
    $display("test silo done");
    MON.tmo(32'h0001_2340);
    MON.tmo(32'h0005_6780);
    rd(IDX_TMO_ADDR, 32'h0001_2340, "tmo addr");
    rd(IDX_FAULT_SUM, 32'h0000_0007, "tmo flag");
    wb(1'b1, IDX_CLR_TMO, 32'h0000_0000);
    rd(IDX_FAULT_SUM, 32'h0000_0005, "tmo clear");
    wb(1'b1, IDX_INT_OTHER, 32'h0000_0000);
    `CHK("other cpu", 2'b10, pls)
    wb(1'b1, IDX_WBUF_DRAIN, 32'hFFFF_FFFF);
    `CHK("drain", 2'b01, pls)
    $display("test trigger done");
    test_done();
  end
endmodule
`default_nettype wire
